// [pkg/sps_consts.svh]
/*
 Constants of the shunt power scaling engine: register indices, reset values,
 field positions and arithmetic divisors. Definitions only.
*/
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
// Register indices, byte address is four times the index
`define SPS_IDX_CFG 6'h00
`define SPS_IDX_SHUNT 6'h01
`define SPS_IDX_BUS 6'h02
`define SPS_IDX_POWER 6'h03
`define SPS_IDX_CURRENT 6'h04
`define SPS_IDX_CAL 6'h05
// Reset values
`define SPS_CFG_RESET 16'h399f
`define SPS_CAL_RESET 16'h0000
`define SPS_RES_RESET 16'h0000
// Bus voltage register layout
`define SPS_BUS_SHIFT 3
`define SPS_BUS_CNVR_BIT 1
`define SPS_BUS_OVF_BIT 0
// Modes that keep the conversion-ready flag on a configuration write
`define SPS_MODE_PWRDN 3'h0
`define SPS_MODE_ADCOFF 3'h4
// Scaling
`define SPS_CUR_DIV 4095
`define SPS_PWR_DIV 5000
`define SPS_CUR_MAX 16'h7fff
`define SPS_PWR_MAX 16'hffff
// Bus answers
`define SPS_RESP_OKAY 2'h0
`define SPS_RESP_SLVERR 2'h2
`endif

// [pkg/sps_pkg.sv]
/*
 Types of the shunt power scaling engine.
 Assumes the constants header is compiled alongside.
*/
package sps_pkg;
	typedef struct packed {
		logic swReset;
		logic rsvd;
		logic busRange;
		logic [1:0] shuntGain;
		logic [3:0] busAdc;
		logic [3:0] shuntAdc;
		logic [2:0] mode;
	} sps_cfg_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} sps_wr_t;
	typedef enum {SEQ_IDLE, SEQ_CUR, SEQ_PWR} sps_seq_t;
	typedef enum {MD_IDLE, MD_RUN} sps_md_t;
endpackage

// [hdl/sps_muldiv.sv]
/*
 Iterative multiply then divide by a constant, saturated at a limit.
 Assumes a start restarts any running operation and ce gates all state.
*/
`timescale 1ns/100ps
module sps_muldiv
	import sps_pkg::*;
#(
	parameter int OPW = 16,
	parameter int DIVISOR = 4095,
	parameter logic [OPW-1:0] LIMIT = 16'h7fff
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic start,
	input wire logic [OPW-1:0] opA,
	input wire logic [OPW-1:0] opB,
	output logic done,
	output logic ovf,
	output logic [OPW-1:0] result
);
	localparam int PW = 2*OPW;
	localparam int RW = OPW+2;
	sps_md_t state_ff, nxt_state;
	logic [PW-1:0] dvd_ff, nxt_dvd, quo_ff, nxt_quo, chkProd_ff, expQ;
	logic [RW-1:0] rem_ff, nxt_rem, remSh;
	logic [$clog2(PW)-1:0] cnt_ff, nxt_cnt;
	logic neg_ff, nxt_neg, done_ff, nxt_done, ovf_ff, nxt_ovf, chkNeg_ff;
	logic [OPW-1:0] res_ff, nxt_res, magA, magQ, expMag;
	assign magA = opA[OPW-1] ? OPW'(-opA) : opA;
	assign remSh = {rem_ff[RW-2:0], dvd_ff[PW-1]};
	assign magQ = (nxt_quo > PW'(LIMIT)) ? LIMIT : nxt_quo[OPW-1:0];
	always_comb
	begin
		nxt_state = state_ff;
		nxt_dvd = dvd_ff;
		nxt_rem = rem_ff;
		nxt_quo = quo_ff;
		nxt_cnt = cnt_ff;
		nxt_neg = neg_ff;
		nxt_done = 1'b0;
		nxt_ovf = ovf_ff;
		nxt_res = res_ff;
		if (start)
		begin
			nxt_dvd = PW'(magA) * PW'(opB);
			nxt_rem = '0;
			nxt_quo = '0;
			nxt_cnt = '0;
			nxt_neg = opA[OPW-1];
			nxt_state = MD_RUN;
		end
		else if (state_ff == MD_RUN)
		begin
			nxt_dvd = {dvd_ff[PW-2:0], 1'b0};
			nxt_rem = (remSh >= RW'(DIVISOR)) ? remSh - RW'(DIVISOR) : remSh;
			nxt_quo = {quo_ff[PW-2:0], remSh >= RW'(DIVISOR)};
			nxt_cnt = cnt_ff + 1'b1;
			if (cnt_ff == ($clog2(PW))'(PW-1))
			begin
				nxt_state = MD_IDLE;
				nxt_done = 1'b1;
				nxt_ovf = nxt_quo > PW'(LIMIT);
				nxt_res = neg_ff ? OPW'(-magQ) : magQ;
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_ff <= MD_IDLE;
			dvd_ff <= '0;
			rem_ff <= '0;
			quo_ff <= '0;
			cnt_ff <= '0;
			neg_ff <= 1'b0;
			done_ff <= 1'b0;
			ovf_ff <= 1'b0;
			res_ff <= '0;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
			dvd_ff <= nxt_dvd;
			rem_ff <= nxt_rem;
			quo_ff <= nxt_quo;
			cnt_ff <= nxt_cnt;
			neg_ff <= nxt_neg;
			done_ff <= nxt_done;
			ovf_ff <= nxt_ovf;
			res_ff <= nxt_res;
		end
	end
	assign done = done_ff;
	assign ovf = ovf_ff;
	assign result = res_ff;
	////////////////////////////////////////////////////////////////////////////////
	// Reference product for checking
	always_ff @(posedge clk)
	begin
		if (ce && start)
		begin
			chkProd_ff <= PW'(magA) * PW'(opB);
			chkNeg_ff <= opA[OPW-1];
		end
	end
	assign expQ = chkProd_ff / PW'(DIVISOR);
	assign expMag = (expQ > PW'(LIMIT)) ? LIMIT : expQ[OPW-1:0];
	scaled_result_a: assert property (@(posedge clk) disable iff (rst) // RULE8
		done_ff |-> res_ff == (chkNeg_ff ? OPW'(-expMag) : expMag)
			&& ovf_ff == (expQ > PW'(LIMIT)))
		else $error("Scaled result differs from product over divisor");
endmodule

// [hdl/sps_axil_slave.sv]
/*
 AXI4-Lite slave front end: takes write address and data in either order,
 one write and one read at a time. Assumes the register file decodes in the
 same cycle as the fire strobes.
*/
`timescale 1ns/100ps
module sps_axil_slave
	import sps_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wrFire,
	output sps_wr_t wrReq,
	input wire logic wrErr,
	output logic rdFire,
	input wire logic [31:0] rdData,
	input wire logic rdErr
);
	`include "sps_consts.svh"
	sps_wr_t wr_ff, nxt_wr;
	logic awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld, awready_ff, nxt_awready;
	logic wready_ff, nxt_wready, bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
	logic rvalid_ff, nxt_rvalid, awTake, wTake;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	assign awTake = awvalid && awready_ff;
	assign wTake = wvalid && wready_ff;
	assign rdFire = arvalid && arready_ff;
	assign wrReq = nxt_wr;
	always_comb
	begin
		nxt_wr = wr_ff;
		if (awTake) nxt_wr.addr = awaddr;
		if (wTake) nxt_wr.data = wdata;
		if (wTake) nxt_wr.strb = wstrb;
		nxt_awHeld = awHeld_ff || awTake;
		nxt_wHeld = wHeld_ff || wTake;
		wrFire = nxt_awHeld && nxt_wHeld;
		nxt_bvalid = bvalid_ff && !bready;
		nxt_bresp = bresp_ff;
		if (wrFire)
		begin
			nxt_awHeld = 1'b0;
			nxt_wHeld = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = wrErr ? `SPS_RESP_SLVERR : `SPS_RESP_OKAY;
		end
		nxt_awready = !nxt_awHeld && !nxt_bvalid;
		nxt_wready = !nxt_wHeld && !nxt_bvalid;
		nxt_rvalid = rvalid_ff && !rready;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (rdFire)
		begin
			nxt_rvalid = 1'b1;
			nxt_rdata = rdData;
			nxt_rresp = rdErr ? `SPS_RESP_SLVERR : `SPS_RESP_OKAY;
		end
		nxt_arready = !nxt_rvalid;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_ff <= '0;
			{awHeld_ff, wHeld_ff, awready_ff, wready_ff, bvalid_ff} <= 5'h00;
			{arready_ff, rvalid_ff, bresp_ff, rresp_ff} <= 6'h00;
			rdata_ff <= 32'h0000_0000;
		end
		else if (ce)
		begin
			wr_ff <= nxt_wr;
			{awHeld_ff, wHeld_ff, awready_ff, wready_ff} <= {nxt_awHeld, nxt_wHeld, nxt_awready, nxt_wready};
			{bvalid_ff, arready_ff, rvalid_ff} <= {nxt_bvalid, nxt_arready, nxt_rvalid};
			{bresp_ff, rresp_ff, rdata_ff} <= {nxt_bresp, nxt_rresp, nxt_rdata};
		end
	end
	assign {awready, wready, bvalid, bresp} = {awready_ff, wready_ff, bvalid_ff, bresp_ff};
	assign {arready, rvalid, rresp, rdata} = {arready_ff, rvalid_ff, rresp_ff, rdata_ff};
endmodule

// [hdl/sps_scaling_engine.sv]
/*
 Shunt power scaling engine: configuration and calibration registers,
 raw shunt and bus results, current and power scaling, AXI4-Lite access.
 Assumes the converter delivers a signed shunt word and a 13-bit bus word
 with a one-cycle strobe, synchronous to ref_clk.
*/
//
// Contract
// RULE1 - After reset the configuration selects continuous 12-bit conversion, divide-by-eight gain and the 32V range.
// RULE2 - Current and power are computed only with a nonzero calibration word, and read zero otherwise.
// RULE3 - Every register returns to its default at reset or software reset, so the host must rewrite its settings.
// RULE4 - The host derives the calibration word as the truncated 0.04096 over current step times shunt resistance.
// RULE5 - The bus result step is fixed at 4mV, so the power step is twenty times the current step.
// RULE6 - The current result is signed with a largest magnitude of 32767 counts.
// RULE7 - The host may refine calibration by scaling it with measured over reported current.
// RULE8 - Current is the raw shunt result times calibration, divided by 4095.
// RULE9 - Power is the current times the right-aligned bus result, divided by 5000.
// RULE10 - The bus result sits left-justified, its lowest measurement bit three places above bit zero.
`timescale 1ns/100ps
module sps_scaling_engine
	import sps_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic convStrobe,
	input wire logic [15:0] shuntRaw,
	input wire logic [12:0] busRaw,
	output sps_cfg_t cfgOut,
	output logic calValid,
	output logic convReady
);
	`include "sps_consts.svh"
	sps_wr_t wrReq;
	sps_cfg_t cfg_ff, nxt_cfg, cfgMerged;
	sps_seq_t seq_ff, nxt_seq;
	logic wrFire, wrErr, rdFire, rdErr;
	logic [5:0] wrIdx, rdIdx;
	logic [31:0] rdData;
	logic [15:0] cal_ff, nxt_cal, shunt_ff, nxt_shunt, bus_ff, nxt_bus;
	logic [15:0] cur_ff, nxt_cur, pwr_ff, nxt_pwr;
	logic calValid_ff, nxt_calValid;
	logic swReset, cfgWrite, calWrite, cnvrClear;
	logic curStart, pwrStart, curDone, curOvf, pwrDone, pwrOvf;
	logic [15:0] curRes, pwrRes, curMag, pwrOpB;

	////////////////////////////////////////////////////////////////////////////////
	// Bus front end
	sps_axil_slave u_slave (
		.clk(ref_clk),
		.rst(rst),
		.ce(clkEn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wrFire(wrFire),
		.wrReq(wrReq),
		.wrErr(wrErr),
		.rdFire(rdFire),
		.rdData(rdData),
		.rdErr(rdErr)
	);
	assign wrIdx = wrReq.addr[7:2];
	assign rdIdx = araddr[7:2];
	assign wrErr = wrIdx > `SPS_IDX_CAL;
	assign rdErr = rdIdx > `SPS_IDX_CAL;
	assign cfgWrite = wrFire && wrIdx == `SPS_IDX_CFG;
	assign calWrite = wrFire && wrIdx == `SPS_IDX_CAL;
	always_comb
	begin
		cfgMerged = cfg_ff;
		if (wrReq.strb[0]) cfgMerged[7:0] = wrReq.data[7:0];
		if (wrReq.strb[1]) cfgMerged[15:8] = wrReq.data[15:8];
		cfgMerged.rsvd = 1'b0;
	end
	assign swReset = cfgWrite && cfgMerged.swReset;
	assign cnvrClear = (cfgWrite && cfgMerged.mode != `SPS_MODE_PWRDN
		&& cfgMerged.mode != `SPS_MODE_ADCOFF) || (rdFire && rdIdx == `SPS_IDX_BUS);
	always_comb
	begin
		case (rdIdx)
			`SPS_IDX_CFG: rdData = {16'h0000, cfg_ff};
			`SPS_IDX_SHUNT: rdData = {16'h0000, shunt_ff};
			`SPS_IDX_BUS: rdData = {16'h0000, bus_ff};
			`SPS_IDX_POWER: rdData = {16'h0000, pwr_ff};
			`SPS_IDX_CURRENT: rdData = {16'h0000, cur_ff};
			`SPS_IDX_CAL: rdData = {16'h0000, cal_ff};
			default: rdData = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration and calibration
	always_comb
	begin
		nxt_cfg = cfg_ff;
		nxt_cal = cal_ff;
		if (swReset)
		begin
			nxt_cfg = `SPS_CFG_RESET; // RULE3
			nxt_cal = `SPS_CAL_RESET; // RULE3
		end
		else
		begin
			if (cfgWrite) nxt_cfg = cfgMerged;
			if (calWrite && wrReq.strb[0]) nxt_cal[7:0] = wrReq.data[7:0];
			if (calWrite && wrReq.strb[1]) nxt_cal[15:8] = wrReq.data[15:8];
		end
		nxt_calValid = nxt_cal != 16'h0000;
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			cfg_ff <= `SPS_CFG_RESET; // RULE1
			cal_ff <= `SPS_CAL_RESET;
			calValid_ff <= 1'b0;
		end
		else if (clkEn)
		begin
			cfg_ff <= nxt_cfg;
			cal_ff <= nxt_cal;
			calValid_ff <= nxt_calValid;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Scaling units
	assign curMag = curRes[15] ? 16'(-curRes) : curRes;
	assign pwrOpB = 16'(bus_ff >> `SPS_BUS_SHIFT);
	sps_muldiv #(.OPW(16), .DIVISOR(`SPS_CUR_DIV), .LIMIT(`SPS_CUR_MAX)) u_cur ( // RULE8
		.clk(ref_clk),
		.rst(rst),
		.ce(clkEn),
		.start(curStart),
		.opA(shuntRaw),
		.opB(cal_ff),
		.done(curDone),
		.ovf(curOvf),
		.result(curRes)
	);
	sps_muldiv #(.OPW(16), .DIVISOR(`SPS_PWR_DIV), .LIMIT(`SPS_PWR_MAX)) u_pwr ( // RULE9
		.clk(ref_clk),
		.rst(rst),
		.ce(clkEn),
		.start(pwrStart),
		.opA(curMag),
		.opB(pwrOpB),
		.done(pwrDone),
		.ovf(pwrOvf),
		.result(pwrRes)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Result sequencing
	always_comb
	begin
		nxt_seq = seq_ff;
		nxt_shunt = shunt_ff;
		nxt_bus = bus_ff;
		nxt_cur = cur_ff;
		nxt_pwr = pwr_ff;
		curStart = 1'b0;
		pwrStart = 1'b0;
		if (convStrobe)
		begin
			nxt_shunt = shuntRaw;
			nxt_bus[15:`SPS_BUS_SHIFT] = busRaw; // RULE10
		end
		if (cnvrClear) nxt_bus[`SPS_BUS_CNVR_BIT] = 1'b0;
		unique case (seq_ff)
			SEQ_IDLE:
			if (convStrobe)
			begin
				if (cal_ff == `SPS_CAL_RESET)
				begin
					nxt_cur = `SPS_RES_RESET; // RULE2
					nxt_pwr = `SPS_RES_RESET; // RULE2
					nxt_bus[`SPS_BUS_OVF_BIT] = 1'b0;
					nxt_bus[`SPS_BUS_CNVR_BIT] = 1'b1;
				end
				else
				begin
					curStart = 1'b1;
					nxt_seq = SEQ_CUR;
				end
			end
			SEQ_CUR:
			if (curDone)
			begin
				nxt_cur = curRes; // RULE6
				nxt_bus[`SPS_BUS_OVF_BIT] = curOvf;
				pwrStart = 1'b1;
				nxt_seq = SEQ_PWR;
			end
			SEQ_PWR:
			if (pwrDone)
			begin
				nxt_pwr = pwrRes; // RULE5
				nxt_bus[`SPS_BUS_OVF_BIT] = bus_ff[`SPS_BUS_OVF_BIT] || pwrOvf;
				nxt_bus[`SPS_BUS_CNVR_BIT] = 1'b1;
				nxt_seq = SEQ_IDLE;
			end
		endcase
		if (swReset)
		begin
			nxt_seq = SEQ_IDLE; // RULE3
			nxt_shunt = `SPS_RES_RESET;
			nxt_bus = `SPS_RES_RESET;
			nxt_cur = `SPS_RES_RESET;
			nxt_pwr = `SPS_RES_RESET;
			curStart = 1'b0;
			pwrStart = 1'b0;
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			seq_ff <= SEQ_IDLE;
			shunt_ff <= `SPS_RES_RESET;
			bus_ff <= `SPS_RES_RESET;
			cur_ff <= `SPS_RES_RESET;
			pwr_ff <= `SPS_RES_RESET;
		end
		else if (clkEn)
		begin
			seq_ff <= nxt_seq;
			shunt_ff <= nxt_shunt;
			bus_ff <= nxt_bus;
			cur_ff <= nxt_cur;
			pwr_ff <= nxt_pwr;
		end
	end
	assign cfgOut = cfg_ff;
	assign calValid = calValid_ff;
	assign convReady = bus_ff[`SPS_BUS_CNVR_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	cfg_default_a: assert property ($fell(rst) |-> cfg_ff == `SPS_CFG_RESET) // RULE1
		else $error("Configuration not at default after reset");
	reset_clear_a: assert property ($fell(rst) |-> cal_ff == 16'h0000 // RULE3
		&& cur_ff == 16'h0000 && pwr_ff == 16'h0000 && !calValid_ff)
		else $error("Registers not cleared after reset");
	sw_reset_a: assert property (clkEn && swReset |=> cfg_ff == `SPS_CFG_RESET // RULE3
		&& cal_ff == 16'h0000 && seq_ff == SEQ_IDLE)
		else $error("Software reset did not restore defaults");
	cal_gate_a: assert property (clkEn && convStrobe && seq_ff == SEQ_IDLE // RULE2
		&& cal_ff == 16'h0000 && !swReset |=> cur_ff == 16'h0000 && pwr_ff == 16'h0000
		&& seq_ff == SEQ_IDLE && convReady)
		else $error("Results not zero with unprogrammed calibration");
	cur_range_a: assert property (cur_ff != 16'h8000) // RULE6
		else $error("Current result beyond signed limit");
	power_step_a: assert property (pwrStart |-> pwrOpB[15:13] == 3'h0 // RULE5
		&& pwrOpB[12:0] == bus_ff[15:3])
		else $error("Power not scaled by right-aligned bus result");
	bus_align_a: assert property (clkEn && convStrobe && !swReset // RULE10
		|=> bus_ff[15:3] == $past(busRaw) && bus_ff[2] == 1'b0)
		else $error("Bus result not left-justified");
	ready_set_a: assert property (clkEn && pwrDone && seq_ff == SEQ_PWR && !swReset // RULE9
		|=> convReady && pwr_ff == $past(pwrRes))
		else $error("Power result not stored on completion");
	full_calc_c: cover property (clkEn && pwrDone && seq_ff == SEQ_PWR && cal_ff != 16'h0000);
	cur_ovf_c: cover property (clkEn && curDone && curOvf);
	sw_reset_c: cover property (clkEn && swReset);
	neg_cur_c: cover property (clkEn && curDone && curRes[15]);
endmodule

// [bench/sps_host_model.sv]
/*
 Host model of the register bus: AXI4-Lite master tasks and the host's calibration arithmetic.
 Assumes one clock and a slave that answers each channel by its own ready.
*/
`timescale 1ns/100ps
module sps_host_model
	import sps_pkg::*;
(
	input wire logic ref_clk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial
	begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Write: address and data offered together, each released when taken
	task automatic axiWrite(input logic [7:0] addr, input logic [15:0] data,
		input logic [3:0] strb, output logic [1:0] resp);
		logic awOpen;
		logic wOpen;
		@(posedge ref_clk);
		awaddr <= addr;
		awvalid <= 1'b1;
		wdata <= {16'h0000, data};
		wstrb <= strb;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awOpen = 1'b1;
		wOpen = 1'b1;
		while (awOpen || wOpen)
		begin
			@(posedge ref_clk);
			if (awOpen && awready === 1'b1)
			begin
				awOpen = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~addr;
			end
			if (wOpen && wready === 1'b1)
			begin
				wOpen = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~{16'h0000, data};
			end
		end
		do
			@(posedge ref_clk);
		while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Read: address held until taken, rready held until data arrives
	task automatic axiRead(input logic [7:0] addr, output logic [31:0] data,
		output logic [1:0] resp);
		@(posedge ref_clk);
		araddr <= addr;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge ref_clk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~addr;
		do
			@(posedge ref_clk);
		while (rvalid !== 1'b1);
		data = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Calibration word from current step in nA and shunt in micro-ohm, truncated
	function automatic logic [15:0] calCalc(input longint stepNa, input longint shuntUohm);
		calCalc = 16'(64'sd40960000000000 / (stepNa * shuntUohm));
	endfunction
	// Refined word scaled by measured over reported current, truncated
	function automatic logic [15:0] calRefine(input logic [15:0] cal, input longint measured,
		input longint reported);
		calRefine = 16'((longint'(cal) * measured) / reported);
	endfunction
endmodule

// [bench/test_sps_scaling_engine.sv]
/*
 Self-checking bench of the scaling engine: register tasks over the host model, converter stimulus.
 Assumes the constants header is on the include path.
*/
`timescale 1ns/100ps
`include "sps_consts.svh"
`define CHK(what, exp, got) \
	begin \
		nTests++; \
		if ((got) !== (exp)) \
		begin \
			nMismatch++; \
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
		end \
	end
module test_sps_scaling_engine
	import sps_pkg::*;
;
	logic ref_clk, rst, clkEn, convStrobe, calValid, convReady;
	logic [15:0] shuntRaw;
	logic [12:0] busRaw;
	sps_cfg_t cfgOut;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int nMismatch = 0;
	int nTests = 0;
	int cycles = 0;
	logic [15:0] tCal[5], tSh[5], tCur[5], tPwr[5];
	logic [12:0] tBus[5];
	logic [4:0] tOvf;
	sps_scaling_engine sps_scaling_engine_inst (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .convStrobe(convStrobe), .shuntRaw(shuntRaw),
		.busRaw(busRaw), .cfgOut(cfgOut), .calValid(calValid), .convReady(convReady));
	sps_host_model sps_host_model_inst (.ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic tallyAndFinish();
		if (nMismatch == 0 && nTests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic regWr(input logic [5:0] idx, input logic [15:0] data, input logic [3:0] strb,
		input logic [1:0] expResp);
		logic [1:0] resp;
		sps_host_model_inst.axiWrite({idx, 2'b00}, data, strb, resp);
		`CHK("write response", expResp, resp)
	endtask
	task automatic regChk(input logic [5:0] idx, input logic [15:0] exp, input logic [1:0] expResp);
		logic [31:0] data;
		logic [1:0] resp;
		sps_host_model_inst.axiRead({idx, 2'b00}, data, resp);
		`CHK("read data", {16'h0000, exp}, data)
		`CHK("read response", expResp, resp)
	endtask
	task automatic convert(input logic [15:0] sh, input logic [12:0] bv, input int hold);
		int n;
		@(posedge ref_clk);
		convStrobe <= 1'b1;
		shuntRaw <= sh;
		busRaw <= bv;
		@(posedge ref_clk);
		convStrobe <= 1'b0;
		// Freeze the block mid-computation; results must still come out intact
		if (hold > 0)
		begin
			clkEn <= 1'b0;
			repeat (hold) @(posedge ref_clk);
			`CHK("frozen ready", 1'b0, convReady)
			clkEn <= 1'b1;
		end
		n = 0;
		while (convReady !== 1'b1 && n < 200)
		begin
			@(posedge ref_clk);
			n++;
		end
		`CHK("result ready", 1'b1, convReady)
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever
		begin
			@(posedge ref_clk);
			cycles++;
			if (cycles == 6000)
			begin
				nMismatch++;
				tallyAndFinish();
			end
		end
	end
	initial
	begin
		rst = 1'b1;
		clkEn = 1'b1;
		convStrobe = 1'b0;
		shuntRaw = 16'h0000;
		busRaw = 13'h0000;
		tCal = '{16'h0000, 16'h0000, 16'h0fff, 16'h1ffe, 16'h1ffe};
		tSh = '{16'h07d0, 16'h07d0, 16'hfc18, 16'h7fff, 16'h8001};
		tBus = '{13'd2995, 13'd2995, 13'd5000, 13'd5000, 13'd100};
		tCur = '{16'h2712, 16'h2710, 16'hfc18, 16'h7fff, 16'h8001};
		tPwr = '{16'h1767, 16'h1766, 16'h03e8, 16'h7fff, 16'h028f};
		// Overflow flag expected where the current saturates
		tOvf = 5'h18;
		tCal[0] = sps_host_model_inst.calCalc(1000000, 2000);
		tCal[1] = sps_host_model_inst.calRefine(tCal[0], 10000, 10002);
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		// Defaults after reset
		`CHK("config port", 16'h399f, cfgOut)
		`CHK("mode field", 3'h7, cfgOut.mode)
		`CHK("gain field", 2'h3, cfgOut.shuntGain)
		`CHK("bus range field", 1'b1, cfgOut.busRange)
		`CHK("bus resolution", 4'h3, cfgOut.busAdc)
		`CHK("shunt resolution", 4'h3, cfgOut.shuntAdc)
		regChk(`SPS_IDX_CFG, 16'h399f, `SPS_RESP_OKAY);
		regChk(`SPS_IDX_CAL, 16'h0000, `SPS_RESP_OKAY);
		// Uncalibrated conversion gives raw results only
		convert(16'h07d0, 13'd2995, 0);
		regChk(`SPS_IDX_SHUNT, 16'h07d0, `SPS_RESP_OKAY);
		regChk(`SPS_IDX_CURRENT, 16'h0000, `SPS_RESP_OKAY);
		regChk(`SPS_IDX_POWER, 16'h0000, `SPS_RESP_OKAY);
		`CHK("calibration flag", 1'b0, calValid)
		regChk(`SPS_IDX_BUS, 16'h5d9a, `SPS_RESP_OKAY);
		// Calibrated conversions: example, refined, negative, saturated both ways
		for (int i = 0; i < 5; i++)
		begin
			regWr(`SPS_IDX_CAL, tCal[i], 4'h3, `SPS_RESP_OKAY);
			regChk(`SPS_IDX_CAL, tCal[i], `SPS_RESP_OKAY);
			`CHK("calibration flag", 1'b1, calValid)
			convert(tSh[i], tBus[i], (i == 2) ? 20 : 0);
			regChk(`SPS_IDX_CURRENT, tCur[i], `SPS_RESP_OKAY);
			regChk(`SPS_IDX_POWER, tPwr[i], `SPS_RESP_OKAY);
			regChk(`SPS_IDX_BUS, {tBus[i], 2'b01, tOvf[i]}, `SPS_RESP_OKAY);
		end
		// Read-only and unmapped places
		regWr(`SPS_IDX_SHUNT, 16'h1234, 4'h3, `SPS_RESP_OKAY);
		regChk(`SPS_IDX_SHUNT, 16'h8001, `SPS_RESP_OKAY);
		regWr(6'h06, 16'h1234, 4'h3, `SPS_RESP_SLVERR);
		regChk(6'h06, 16'h0000, `SPS_RESP_SLVERR);
		// Non-default setup, then software reset restores defaults
		regWr(`SPS_IDX_CFG, 16'h019f, 4'h3, `SPS_RESP_OKAY);
		`CHK("config port", 16'h019f, cfgOut)
		regWr(`SPS_IDX_CFG, 16'h8000, 4'h2, `SPS_RESP_OKAY);
		regChk(`SPS_IDX_CFG, 16'h399f, `SPS_RESP_OKAY);
		regChk(`SPS_IDX_CAL, 16'h0000, `SPS_RESP_OKAY);
		regChk(`SPS_IDX_CURRENT, 16'h0000, `SPS_RESP_OKAY);
		regChk(`SPS_IDX_POWER, 16'h0000, `SPS_RESP_OKAY);
		`CHK("calibration flag", 1'b0, calValid)
		// Host rewrites its calibration after the reset
		regWr(`SPS_IDX_CAL, tCal[0], 4'h3, `SPS_RESP_OKAY);
		convert(16'h07d0, 13'd2995, 0);
		regChk(`SPS_IDX_CURRENT, 16'h2712, `SPS_RESP_OKAY);
		regChk(`SPS_IDX_POWER, 16'h1767, `SPS_RESP_OKAY);
		tallyAndFinish();
	end
endmodule
